// >>> logic/adc_sel_pkg.sv
package adc_sel_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_POS_SEL  = 6'h0C;
  localparam logic [5:0] IDX_NEG_SEL  = 6'h0D;
  localparam logic [5:0] IDX_RESULT0  = 6'h10;
  localparam logic [5:0] IDX_RESULT1  = 6'h11;
  localparam logic [5:0] IDX_RESULT2  = 6'h12;
  localparam logic [5:0] IDX_RESULT3  = 6'h13;
  localparam logic [5:0] IDX_SAMPLE_L = 6'h14;
  localparam logic [5:0] IDX_SAMPLE_H = 6'h15;
  localparam logic [5:0] IDX_CONTROL  = 6'h0A;
  // selector fields
  localparam int         ROUTE_LSB    = 6;
  localparam int         ROUTE_MSB    = 7;
  localparam int         CODE_MSB     = 5;
  localparam logic [1:0] ROUTE_DIRECT = 2'h0;
  localparam logic [1:0] ROUTE_AMP    = 2'h1;
  // control register fields
  localparam int         START_LSB    = 0;
  localparam int         START_MSB    = 2;
  localparam int         DIFFERENTIAL_SELECT_BIT     = 7;
  localparam int         AMP_EN_BIT   = 8;
  localparam int         LOW_LATENCY_KEEP_ON_BIT   = 9;
  localparam logic [2:0] START_ON_POS = 3'h2;
  localparam logic [2:0] START_ON_NEG = 3'h3;
  // source codes
  localparam logic [5:0] CODE_GND0    = 6'h00;
  localparam logic [5:0] CODE_GND1    = 6'h30;
  localparam logic [5:0] CODE_SUPPLY  = 6'h31;
  localparam logic [5:0] CODE_TEMP    = 6'h32;
  localparam logic [5:0] CODE_DACREF  = 6'h33;
  localparam logic [5:0] POS_PIN_MAX  = 6'h0F;
  localparam logic [5:0] NEG_PIN_MAX  = 6'h07;
  // reset values
  localparam logic [7:0]  SEL_RESET    = 8'h00;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [15:0] SAMPLE_RESET = 16'h0000;

  typedef enum logic [2:0] {
    SRC_GROUND,
    SRC_PIN,
    SRC_SUPPLY_TENTH,
    SRC_TEMPERATURE,
    SRC_DAC_REFERENCE,
    SRC_RESERVED
  } src_kind_t;
endpackage

// >>> logic/adc_input_select.sv
// Functional notes
// - route code 0 connects inputs directly, 1 via amplifier, others reserved.
// - one shared route field, written through either selector register.
// - positive codes: ground, pins 1-15, supply tenth, temperature, dac reference.
// - negative codes: ground, pins 1-7, supply tenth, dac reference only.
// - both selectors fully read/write, reset to zero.
// - 32-bit read-only result in four bytes from base, reset zero.
// - result byte n sits at base plus 4n, byte 3 holds top bits.
// - 16-bit read-only latest sample, reset zero.
// - sample low byte at base, high byte at base plus four.
// - differential clear uses positive only unsigned; set uses both, signed.
// - start field 2 starts on positive write, 3 on negative write.
// - sample updates per conversion; result takes accumulated value.
// - amplifier powered only when enabled and either routed through it or low latency set.
module adc_input_select #(
  parameter int ADDR_W = 8
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [ADDR_W-1:0]        haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic                     sample_valid,
  input  wire logic [15:0]              sample_in,
  input  wire logic                     result_valid,
  input  wire logic [31:0]              result_in,
  output logic                          start_conversion,
  output logic                          differential_mode,
  output logic                          signed_result,
  output logic [5:0]                    pos_code,
  output logic [5:0]                    neg_code,
  output adc_sel_pkg::src_kind_t        pos_kind,
  output adc_sel_pkg::src_kind_t        neg_kind,
  output logic [3:0]                    pos_pin,
  output logic [3:0]                    neg_pin,
  output logic                          route_via_amp,
  output logic                          route_reserved,
  output logic                          amp_power_on
);
  import adc_sel_pkg::*;

  logic [7:0]  pos_sel_reg;
  logic [7:0]  neg_sel_reg;
  logic [1:0]  route_reg;
  logic [1:0]  route_next;
  logic [5:0]  pos_next;
  logic [5:0]  neg_next;
  logic [9:0]  ctrl_reg;
  logic [9:0]  ctrl_next;
  logic [31:0] result_reg;
  logic [15:0] sample_reg;
  logic [23:0] result_hold_reg;
  logic [7:0]  sample_hold_reg;
  logic        wr_pend_reg;
  logic [5:0]  wr_idx_reg;
  logic [31:0] hrdata_reg;
  logic        start_reg;
  logic        addr_take;
  logic [5:0]  addr_idx;
  logic        wr_pos;
  logic        wr_neg;
  logic        wr_ctrl;

  // pin sources map to the pin number, anything else to zero
  function automatic logic [3:0] pin_of(input logic [5:0] code,
                                        input logic [5:0] pin_max);
    pin_of = (code != CODE_GND0 && code <= pin_max) ? code[3:0] : 4'h0;
  endfunction

  // source class of a selector code; negative side has no temperature
  function automatic src_kind_t kind_of(input logic [5:0] code,
                                        input logic       is_neg);
    if (code == CODE_GND0 || code == CODE_GND1)
      kind_of = SRC_GROUND;
    else if (code <= (is_neg ? NEG_PIN_MAX : POS_PIN_MAX))
      kind_of = SRC_PIN;
    else if (code == CODE_SUPPLY)
      kind_of = SRC_SUPPLY_TENTH;
    else if (code == CODE_TEMP && !is_neg)
      kind_of = SRC_TEMPERATURE;
    else if (code == CODE_DACREF)
      kind_of = SRC_DAC_REFERENCE;
    else
      kind_of = SRC_RESERVED;
  endfunction

  // address phase decode; single-cycle slave so hready is ours
  assign addr_take = hsel && htrans[1] && hready;
  assign addr_idx  = haddr[7:2];
  assign wr_pos    = wr_pend_reg && wr_idx_reg == IDX_POS_SEL;
  assign wr_neg    = wr_pend_reg && wr_idx_reg == IDX_NEG_SEL;
  assign wr_ctrl   = wr_pend_reg && wr_idx_reg == IDX_CONTROL;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 6'h00;
    end else begin
      wr_pend_reg <= addr_take && hwrite;
      wr_idx_reg  <= addr_idx;
    end
  end

  // next values include the write in its data phase, so a read right
  // behind a write already sees the new value
  always_comb begin
    route_next = route_reg;
    pos_next   = pos_sel_reg[CODE_MSB:0];
    neg_next   = neg_sel_reg[CODE_MSB:0];
    ctrl_next  = ctrl_reg;
    if (wr_pos || wr_neg)
      route_next = hwdata[ROUTE_MSB:ROUTE_LSB];
    if (wr_pos)
      pos_next = hwdata[CODE_MSB:0];
    if (wr_neg)
      neg_next = hwdata[CODE_MSB:0];
    if (wr_ctrl)
      ctrl_next = hwdata[9:0];
  end

  // selector storage; the route field lives once, shown in both
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_sel_reg <= SEL_RESET;
      neg_sel_reg <= SEL_RESET;
      route_reg   <= SEL_RESET[ROUTE_MSB:ROUTE_LSB];
      ctrl_reg    <= 10'h000;
    end else begin
      pos_sel_reg <= {2'h0, pos_next};
      neg_sel_reg <= {2'h0, neg_next};
      route_reg   <= route_next;
      ctrl_reg    <= ctrl_next;
    end
  end

  // write-triggered start; uses the start field before this write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      start_reg <= 1'b0;
    else
      start_reg <= (wr_pos && ctrl_reg[START_MSB:START_LSB] == START_ON_POS)
                || (wr_neg && ctrl_reg[START_MSB:START_LSB] == START_ON_NEG);
  end

  // conversion data from the core; result only on accumulation end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_reg <= SAMPLE_RESET;
      result_reg <= RESULT_RESET;
    end else begin
      if (sample_valid)
        sample_reg <= sample_in;
      if (result_valid)
        result_reg <= result_in;
    end
  end

  // low-byte read freezes the upper bytes so a new conversion in
  // between cannot tear a multi-byte read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_hold_reg <= RESULT_RESET[31:8];
      sample_hold_reg <= SAMPLE_RESET[15:8];
    end else if (addr_take && !hwrite) begin
      if (addr_idx == IDX_RESULT0)
        result_hold_reg <= result_reg[31:8];
      if (addr_idx == IDX_SAMPLE_L)
        sample_hold_reg <= sample_reg[15:8];
    end
  end

  // read data registered at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata_reg <= 32'h0000_0000;
    else if (addr_take && !hwrite) begin
      unique case (addr_idx)
        IDX_POS_SEL:  hrdata_reg <= {24'h0, route_next, pos_next};
        IDX_NEG_SEL:  hrdata_reg <= {24'h0, route_next, neg_next};
        IDX_CONTROL:  hrdata_reg <= {22'h0, ctrl_next};
        IDX_RESULT0:  hrdata_reg <= {24'h0, result_reg[7:0]};
        IDX_RESULT1:  hrdata_reg <= {24'h0, result_hold_reg[7:0]};
        IDX_RESULT2:  hrdata_reg <= {24'h0, result_hold_reg[15:8]};
        IDX_RESULT3:  hrdata_reg <= {24'h0, result_hold_reg[23:16]};
        IDX_SAMPLE_L: hrdata_reg <= {24'h0, sample_reg[7:0]};
        IDX_SAMPLE_H: hrdata_reg <= {24'h0, sample_hold_reg};
        default:      hrdata_reg <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // analog side controls
  assign start_conversion  = start_reg;
  assign differential_mode = ctrl_reg[DIFFERENTIAL_SELECT_BIT];
  assign signed_result     = ctrl_reg[DIFFERENTIAL_SELECT_BIT];
  assign pos_code          = pos_sel_reg[CODE_MSB:0];
  // negative input parked at ground in single-ended mode
  assign neg_code = ctrl_reg[DIFFERENTIAL_SELECT_BIT] ? neg_sel_reg[CODE_MSB:0]
                                       : CODE_GND0;
  assign pos_kind          = kind_of(pos_sel_reg[CODE_MSB:0], 1'b0);
  assign neg_kind          = ctrl_reg[DIFFERENTIAL_SELECT_BIT]
                           ? kind_of(neg_sel_reg[CODE_MSB:0], 1'b1)
                           : SRC_GROUND;
  assign pos_pin           = pin_of(pos_sel_reg[CODE_MSB:0], POS_PIN_MAX);
  assign neg_pin           = ctrl_reg[DIFFERENTIAL_SELECT_BIT]
                           ? pin_of(neg_sel_reg[CODE_MSB:0], NEG_PIN_MAX)
                           : 4'h0;
  assign route_via_amp     = route_reg == ROUTE_AMP;
  assign route_reserved    = route_reg != ROUTE_AMP
                          && route_reg != ROUTE_DIRECT;
  // low latency trades power for skipping amplifier start-up
  assign amp_power_on = ctrl_reg[AMP_EN_BIT]
                     && (route_via_amp || ctrl_reg[LOW_LATENCY_KEEP_ON_BIT]);

  route_shared_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pos || wr_neg) |=> route_reg == $past(hwdata[7:6]))
    else $error("route field not shared across selectors");

  start_pos_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pos && ctrl_reg[2:0] == 3'h2) |=> start_conversion ##1
      (!start_conversion || $past(wr_pos || wr_neg)))
    else $error("positive write did not start conversion");

  start_neg_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_neg && ctrl_reg[2:0] == 3'h3) |=> start_conversion)
    else $error("negative write did not start conversion");

  start_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start_conversion |-> $past(wr_pos && ctrl_reg[2:0] == 3'h2)
      || $past(wr_neg && ctrl_reg[2:0] == 3'h3))
    else $error("start without triggering write");

  sample_update_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_valid |=> sample_reg == $past(sample_in))
    else $error("sample not updated");

  result_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !result_valid |=> $stable(result_reg))
    else $error("result changed without accumulation end");

  hold_coherent_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && addr_idx == 6'h10) ##1 !hwrite
      |-> result_hold_reg == $past(result_reg[31:8]))
    else $error("result hold not captured");

  amp_power_a: assert property (@(posedge hclk) disable iff (!hresetn)
    amp_power_on |-> ctrl_reg[8] && (route_reg == 2'h1 || ctrl_reg[9]))
    else $error("amplifier powered when not routed");

  neg_temp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (neg_sel_reg[5:0] == 6'h32 && differential_mode)
      |-> neg_kind == SRC_RESERVED)
    else $error("temperature accepted on negative input");

  single_ended_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !differential_mode |-> neg_code == 6'h00 && !signed_result)
    else $error("negative input used in single-ended mode");

  pos_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pos_sel_reg[5:0] >= 6'h01 && pos_sel_reg[5:0] <= 6'h0F)
      |-> pos_kind == SRC_PIN && pos_pin == pos_sel_reg[3:0])
    else $error("positive pin code misdecoded");

  // zero wait states and OKAY only; a master never stalls on us
  bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus answer not ready or not okay");

  pos_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pos |=> pos_code == $past(hwdata[5:0]))
    else $error("positive selector write lost");

  neg_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_neg |=> neg_sel_reg[5:0] == $past(hwdata[5:0]))
    else $error("negative selector write lost");

  route_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pos || wr_neg) |=> $stable(route_reg))
    else $error("route field changed without selector write");

  route_rsv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    route_reg[1] |-> route_reserved && !route_via_amp)
    else $error("reserved route not flagged");

  route_direct_a: assert property (@(posedge hclk) disable iff (!hresetn)
    route_reg == 2'h0 |-> !route_via_amp && !route_reserved)
    else $error("direct route misdecoded");

  amp_kept_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_reg[8] && ctrl_reg[9]) |-> amp_power_on)
    else $error("amplifier not kept on in low latency");

  amp_routed_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_reg[8] && route_reg == 2'h1) |-> amp_power_on)
    else $error("amplifier off while routed through it");

  differential_select_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    differential_mode |-> signed_result && neg_code == neg_sel_reg[5:0])
    else $error("differential mode not using negative input");

  pos_temp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pos_sel_reg[5:0] == 6'h32 |-> pos_kind == SRC_TEMPERATURE)
    else $error("temperature code misdecoded");

  pos_gnd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pos_sel_reg[5:0] == 6'h30 |-> pos_kind == SRC_GROUND && pos_pin == 4'h0)
    else $error("ground code misdecoded");

  neg_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (differential_mode && neg_sel_reg[5:0] >= 6'h01
      && neg_sel_reg[5:0] <= 6'h07)
      |-> neg_kind == SRC_PIN && neg_pin == neg_sel_reg[3:0])
    else $error("negative pin code misdecoded");

  result_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    result_valid |=> result_reg == $past(result_in))
    else $error("result not loaded");

  // read data stands one cycle after the address edge
  result_byte_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && addr_idx == 6'h10)
      |=> hrdata == {24'h0, $past(result_reg[7:0])})
    else $error("result low byte read wrong");

  sample_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && addr_idx == 6'h14)
      |=> hrdata == {24'h0, $past(sample_reg[7:0])})
    else $error("sample low byte read wrong");

  sample_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && addr_idx == 6'h14)
      |=> sample_hold_reg == $past(sample_reg[15:8]))
    else $error("sample hold not captured");
endmodule

// >>> verif/adc_core_model.sv
// converter core stand-in: one sample per start, sum over ACC_N samples
module adc_core_model #(
  parameter int ACC_N = 2,
  parameter int DELAY = 3
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        start_conversion,
  input  wire logic [15:0] next_sample,
  output logic             sample_valid,
  output logic [15:0]      sample_in,
  output logic             result_valid,
  output logic [31:0]      result_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0]  wait_cnt;
  logic [7:0]  cnt;
  logic [31:0] acc;
  // data lines toggle outside valid so stale values never pass for fresh
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wait_cnt, cnt, acc} <= '0;
      {sample_valid, result_valid} <= 2'h0;
      sample_in <= 16'h0000;
      result_in <= 32'h0000_0000;
    end else begin
      sample_valid <= 1'b0;
      result_valid <= 1'b0;
      sample_in <= ~sample_in;
      result_in <= ~result_in;
      if (start_conversion) begin
        wait_cnt <= 4'(DELAY);
      end else if (wait_cnt == 4'h1) begin
        wait_cnt <= 4'h0;
        sample_valid <= 1'b1;
        sample_in <= next_sample;
        if (cnt == 8'(ACC_N - 1)) begin
          result_valid <= 1'b1;
          result_in <= acc + {16'h0000, next_sample};
          acc <= 32'h0000_0000;
          cnt <= 8'h00;
        end else begin
          acc <= acc + {16'h0000, next_sample};
          cnt <= cnt + 8'h01;
        end
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule

// >>> verif/adc_input_select_tb.sv
module adc_input_select_tb import adc_sel_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [5:0] code;
    src_kind_t  pk;
    logic [3:0] pp;
    src_kind_t  nk;
    logic [3:0] np;
  } sel_row_t;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, result_in, v;
  logic        sample_valid, result_valid, start_conversion;
  logic        differential_mode, signed_result, route_via_amp;
  logic        route_reserved, amp_power_on;
  logic [15:0] sample_in, next_sample;
  logic [5:0]  pos_code, neg_code;
  logic [3:0]  pos_pin, neg_pin;
  src_kind_t   pos_kind, neg_kind;
  int          n_errors, num_checks, n_starts;
  localparam logic [7:0] A_CTL = {IDX_CONTROL, 2'b00};
  localparam logic [7:0] A_POS = {IDX_POS_SEL, 2'b00};
  localparam logic [7:0] A_NEG = {IDX_NEG_SEL, 2'b00};
  localparam logic [7:0] A_RES = {IDX_RESULT0, 2'b00};
  localparam logic [7:0] A_SMP = {IDX_SAMPLE_L, 2'b00};
  sel_row_t rows [11] = '{
    '{6'h00, SRC_GROUND, 4'h0, SRC_GROUND, 4'h0},
    '{6'h01, SRC_PIN, 4'h1, SRC_PIN, 4'h1},
    '{6'h07, SRC_PIN, 4'h7, SRC_PIN, 4'h7},
    '{6'h08, SRC_PIN, 4'h8, SRC_RESERVED, 4'h0},
    '{6'h0F, SRC_PIN, 4'hF, SRC_RESERVED, 4'h0},
    '{6'h10, SRC_RESERVED, 4'h0, SRC_RESERVED, 4'h0},
    '{6'h30, SRC_GROUND, 4'h0, SRC_GROUND, 4'h0},
    '{6'h31, SRC_SUPPLY_TENTH, 4'h0, SRC_SUPPLY_TENTH, 4'h0},
    '{6'h32, SRC_TEMPERATURE, 4'h0, SRC_RESERVED, 4'h0},
    '{6'h33, SRC_DAC_REFERENCE, 4'h0, SRC_DAC_REFERENCE, 4'h0},
    '{6'h3F, SRC_RESERVED, 4'h0, SRC_RESERVED, 4'h0}};
  logic [7:0] rst_addr [9] = '{8'h30, 8'h34, 8'h40, 8'h44, 8'h48, 8'h4C,
                               8'h50, 8'h54, 8'hFC};

  adc_input_select #(.ADDR_W(8)) adc_input_select_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_valid(sample_valid), .sample_in(sample_in),
    .result_valid(result_valid), .result_in(result_in),
    .start_conversion(start_conversion),
    .differential_mode(differential_mode), .signed_result(signed_result),
    .pos_code(pos_code), .neg_code(neg_code), .pos_kind(pos_kind),
    .neg_kind(neg_kind), .pos_pin(pos_pin), .neg_pin(neg_pin),
    .route_via_amp(route_via_amp), .route_reserved(route_reserved),
    .amp_power_on(amp_power_on));
  adc_core_model #(.ACC_N(2), .DELAY(3)) adc_core_model_inst (
    .hclk(hclk), .hresetn(hresetn), .start_conversion(start_conversion),
    .next_sample(next_sample), .sample_valid(sample_valid),
    .sample_in(sample_in), .result_valid(result_valid),
    .result_in(result_in));

  // free-running bus clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // count start pulses one edge at a time
  always @(posedge hclk) if (start_conversion === 1'b1) n_starts++;

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_kind(string nm, src_kind_t e, src_kind_t g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %s seen %s", nm, e.name(), g.name());
    end
  endtask
  // bounded wait on a level sampled at rising edges
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    @(posedge hclk);
    while (s !== 1'b1) begin
      n++;
      if (n > 40) begin
        n_errors++;
        final_report;
      end
      @(posedge hclk);
    end
  endtask
  // one single AHB-Lite word transfer; read data taken at data-phase end
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    wait_hi(hreadyout);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_hi(hreadyout);
    v = hrdata;
    #1;
  endtask

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hsize, hwdata} = '0;
    {n_errors, num_checks, n_starts} = '0;
    next_sample = 16'h1111;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rst_addr[i]) begin
      ahb(1'b0, rst_addr[i], 32'h0);
      chk("reset read", 32'h0, v);
    end
    ahb(1'b1, A_RES, 32'hFFFF_FFFF);
    ahb(1'b0, A_RES, 32'h0);
    chk("result ro", 32'h0, v);
    ahb(1'b1, A_CTL, 32'h80);
    chk("signed", 32'h1, 32'(signed_result));
    chk("differential_select", 32'h1, 32'(differential_mode));
    ahb(1'b0, A_CTL, 32'h0);
    chk("ctl read", 32'h80, v);
    chk("okay", 32'h0, 32'(hresp));
    foreach (rows[i]) begin
      ahb(1'b1, A_POS, {26'h0, rows[i].code});
      ahb(1'b1, A_NEG, {26'h0, rows[i].code});
      chk_kind("pos kind", rows[i].pk, pos_kind);
      chk("pos pin", 32'(rows[i].pp), 32'(pos_pin));
      chk("pos code", 32'(rows[i].code), 32'(pos_code));
      chk("neg code", 32'(rows[i].code), 32'(neg_code));
      chk_kind("neg kind", rows[i].nk, neg_kind);
      chk("neg pin", 32'(rows[i].np), 32'(neg_pin));
      ahb(1'b0, A_POS, 32'h0);
      chk("pos read", {26'h0, rows[i].code}, v);
    end
    // shared route field, amplifier power and reserved route
    ahb(1'b1, A_NEG, 32'h03);
    ahb(1'b1, A_POS, 32'h45);
    ahb(1'b0, A_NEG, 32'h0);
    chk("neg route", 32'h43, v);
    chk("via amp", 32'h1, 32'(route_via_amp));
    ahb(1'b1, A_CTL, 32'h180);
    chk("amp on", 32'h1, 32'(amp_power_on));
    ahb(1'b1, A_NEG, 32'h83);
    ahb(1'b0, A_POS, 32'h0);
    chk("pos route", 32'h85, v);
    chk("route rsv", 32'h1, 32'(route_reserved));
    chk("amp off", 32'h0, 32'(amp_power_on));
    ahb(1'b1, A_CTL, 32'h380);
    chk("amp kept", 32'h1, 32'(amp_power_on));
    ahb(1'b1, A_CTL, 32'h03);
    chk("neg unused", 32'h0, 32'(neg_code));
    chk_kind("neg gnd", SRC_GROUND, neg_kind);
    // start on selector writes feeds the core model
    ahb(1'b1, A_POS, 32'h01);
    ahb(1'b1, A_NEG, 32'h02);
    wait_hi(sample_valid);
    ahb(1'b1, A_CTL, 32'h02);
    next_sample <= 16'hFF80;
    ahb(1'b1, A_POS, 32'h01);
    wait_hi(result_valid);
    repeat (2) @(posedge hclk);
    chk("starts", 32'h2, 32'(n_starts));
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, A_RES + 8'(4 * i), 32'h0);
      chk("result byte", {24'h0, 8'(32'h0001_1091 >> (8 * i))}, v);
    end
    ahb(1'b0, A_SMP, 32'h0);
    chk("sample lo", 32'h80, v);
    ahb(1'b0, A_SMP + 8'h04, 32'h0);
    chk("sample hi", 32'hFF, v);
    // reset again in mid-run: registers back to zero
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, A_RES, 32'h0);
    chk("rst result", 32'h0, v);
    ahb(1'b0, A_POS, 32'h0);
    chk("rst pos", 32'h0, v);
    final_report;
  end
endmodule
